// ---- inc/srm_cfg.svh ----
`ifndef SRM_CFG_SVH
`define SRM_CFG_SVH
`define SRM_ADDR_W 19
`define SRM_DATA_W 16
`define SRM_BOOT_ADDR 19'h00100
`define SRM_CLK_MHZ 125
`define SRM_CORE_CLK_KHZ 38400
`define SRM_XTAL_KHZ 9600
`define SRM_T_CSOE_NS 45
`define SRM_T_POE_NS 78
`define SRM_T_ACH_NS 45
`define SRM_T_AS_NS 8
`define SRM_T_DF_NS 50
`define SRM_CYC(ns) (((ns) * `SRM_CLK_MHZ + 999) / 1000)
`define SRM_CSOE_CYC `SRM_CYC(`SRM_T_CSOE_NS)
`define SRM_POE_CYC `SRM_CYC(`SRM_T_POE_NS)
`define SRM_BYTE_CYC `SRM_CYC(`SRM_T_ACH_NS)
`define SRM_AS_CYC `SRM_CYC(`SRM_T_AS_NS)
`define SRM_DF_CYC `SRM_CYC(`SRM_T_DF_NS)
`endif

// ---- inc/srm_pkg.sv ----
`default_nettype none
`include "srm_cfg.svh"
package srm_pkg;
   typedef logic [`SRM_ADDR_W-1:0] srm_addr_t;
   typedef logic [`SRM_DATA_W-1:0] srm_data_t;
   typedef logic [3:0] srm_cnt_t;
   typedef enum logic [2:0] {
      SRM_IDLE = 3'b000,
      SRM_SETUP = 3'b001,
      SRM_STROBE = 3'b010,
      SRM_GAP = 3'b011,
      SRM_SLEEP = 3'b100
   } srm_state_e;
   typedef enum logic [1:0] {
      SRM_OWN_BOOT = 2'b00,
      SRM_OWN_DSP = 2'b01,
      SRM_OWN_CPU = 2'b10
   } srm_owner_e;
endpackage
`default_nettype wire

// ---- rtl/srm_mem_port.sv ----
// How it works
// - Drive a 19-bit word address, up to 512 k words.
// - External RAM may be 8 or 16 bits wide.
// - With 8-bit RAM, two byte cycles take three clocks more than one ROM word cycle.
// - Byte-half select is the low RAM address line in 8-bit mode.
// - Read data sampled while read strobe low; write data driven during write.
// - ROM select low only while addressing ROM, high otherwise.
// - RAM select low only while addressing RAM, high otherwise.
// - One shared read strobe, low while the memory drives read data.
// - Writes go only to RAM; the ROM is never written.
// - Firmware and samples live in ROM space, variables in RAM space.
// - Arbiter lets signal and control processors share the one port.
// - Port timing derives from the 125 MHz mclk.
// - Bus pins change only when an access needs it.
// - Sleep input low floats every output pin and halts the port.
// - Running indicator high only once the synthesizer is operating.
// - After reset, first fetch is ROM word 0100H; running indicator low.
`default_nettype none
`include "srm_cfg.svh"
module srm_mem_port
   import srm_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic sleep_request_n,
   input wire logic ram_is_8bit,
   input wire logic dsp_req,
   input wire logic dsp_we,
   input wire logic dsp_ram,
   input wire srm_addr_t dsp_addr,
   input wire srm_data_t dsp_wdata,
   input wire logic cpu_req,
   input wire logic cpu_we,
   input wire logic cpu_ram,
   input wire srm_addr_t cpu_addr,
   input wire srm_data_t cpu_wdata,
   input wire srm_data_t mem_data_in,
   output srm_addr_t mem_word_addr,
   output srm_data_t mem_data_out,
   output logic mem_data_oe,
   output logic pins_oe,
   output logic rom_select_n,
   output logic ram_select_n,
   output logic mem_read_strobe_n,
   output logic ram_write_strobe_n,
   output logic byte_half_select,
   output logic run,
   output srm_data_t rd_data,
   output logic dsp_done,
   output logic cpu_done
);
   localparam srm_cnt_t CSOE_C = srm_cnt_t'(`SRM_CSOE_CYC - 1);
   localparam srm_cnt_t POE_C = srm_cnt_t'(`SRM_POE_CYC - 1);
   localparam srm_cnt_t BYTE_C = srm_cnt_t'(`SRM_BYTE_CYC - 1);
   localparam srm_cnt_t AS_C = srm_cnt_t'(`SRM_AS_CYC - 1);
   localparam srm_cnt_t DF_C = srm_cnt_t'(`SRM_DF_CYC - 1);

   logic rst_q1, rst_n;
   logic slp_q1, sleep_s;
   logic b8_q1, b8_s;
   srm_data_t din_q1, din_s;
   srm_state_e st;
   srm_owner_e owner;
   srm_cnt_t cnt;
   logic boot_pend, last_cpu, acc_we, acc_ram, acc8, half;
   srm_data_t acc_wdata;
   logic grant_dsp, grant_cpu;

   // Reset release synchroniser
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rst_q1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_n <= rst_q1;
      end
   end

   // Pin inputs, two stages each
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         slp_q1 <= 1'b1;
         sleep_s <= 1'b1;
         b8_q1 <= 1'b0;
         b8_s <= 1'b0;
         din_q1 <= '0;
         din_s <= '0;
      end else if (ce) begin
         slp_q1 <= sleep_request_n;
         sleep_s <= slp_q1;
         b8_q1 <= ram_is_8bit;
         b8_s <= b8_q1;
         din_q1 <= mem_data_in;
         din_s <= din_q1;
      end
   end

   // Round robin: whoever went last yields
   assign grant_dsp = dsp_req && (!cpu_req || last_cpu);
   assign grant_cpu = cpu_req && !grant_dsp;

   // Pin drivers float in sleep; only a reset brings them back
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         pins_oe <= 1'b1;
      else if (ce && !sleep_s)
         pins_oe <= 1'b0;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st <= SRM_IDLE;
         owner <= SRM_OWN_BOOT;
         cnt <= '0;
         boot_pend <= 1'b1;
         last_cpu <= 1'b0;
         acc_we <= 1'b0;
         acc_ram <= 1'b0;
         acc8 <= 1'b0;
         half <= 1'b0;
         acc_wdata <= '0;
         mem_word_addr <= '0;
         mem_data_out <= '0;
         mem_data_oe <= 1'b0;
         rom_select_n <= 1'b1;
         ram_select_n <= 1'b1;
         mem_read_strobe_n <= 1'b1;
         ram_write_strobe_n <= 1'b1;
         byte_half_select <= 1'b0;
         run <= 1'b0;
         rd_data <= '0;
         dsp_done <= 1'b0;
         cpu_done <= 1'b0;
      end else if (ce) begin
         dsp_done <= 1'b0;
         cpu_done <= 1'b0;
         if (!sleep_s) begin
            // Halt in place; pins_oe floats the pins on this same edge
            st <= SRM_SLEEP;
            mem_data_oe <= 1'b0;
            rom_select_n <= 1'b1;
            ram_select_n <= 1'b1;
            mem_read_strobe_n <= 1'b1;
            ram_write_strobe_n <= 1'b1;
            run <= 1'b0;
         end else begin
            case (st)
               SRM_IDLE: begin
                  // Address lines keep their level between accesses
                  if (boot_pend) begin
                     boot_pend <= 1'b0;
                     owner <= SRM_OWN_BOOT;
                     mem_word_addr <= `SRM_BOOT_ADDR;
                     acc_we <= 1'b0;
                     acc_ram <= 1'b0;
                     acc8 <= 1'b0;
                     rom_select_n <= 1'b0;
                     cnt <= CSOE_C;
                     st <= SRM_SETUP;
                  end else if (grant_dsp || grant_cpu) begin
                     owner <= grant_dsp ? SRM_OWN_DSP : SRM_OWN_CPU;
                     last_cpu <= grant_cpu;
                     mem_word_addr <= grant_dsp ? dsp_addr : cpu_addr;
                     // Writes to ROM space are turned into ROM reads
                     acc_ram <= grant_dsp ? dsp_ram : cpu_ram;
                     acc_we <= grant_dsp ? (dsp_we && dsp_ram)
                                         : (cpu_we && cpu_ram);
                     acc8 <= b8_s && (grant_dsp ? dsp_ram : cpu_ram);
                     acc_wdata <= grant_dsp ? dsp_wdata : cpu_wdata;
                     half <= 1'b0;
                     byte_half_select <= 1'b0;
                     if (grant_dsp ? dsp_ram : cpu_ram)
                        ram_select_n <= 1'b0;
                     else
                        rom_select_n <= 1'b0;
                     cnt <= CSOE_C;
                     st <= SRM_SETUP;
                  end
               end
               SRM_SETUP: begin
                  if (acc_we) begin
                     mem_data_oe <= 1'b1;
                     mem_data_out <= half ? {8'h00, acc_wdata[15:8]}
                                   : (acc8 ? {8'h00, acc_wdata[7:0]}
                                           : acc_wdata);
                  end
                  if (cnt == 4'h0) begin
                     if (acc_we)
                        ram_write_strobe_n <= 1'b0;
                     else
                        mem_read_strobe_n <= 1'b0;
                     cnt <= acc8 ? BYTE_C : POE_C;
                     st <= SRM_STROBE;
                  end else begin
                     cnt <= cnt - 4'h1;
                  end
               end
               SRM_STROBE: begin
                  if (cnt == 4'h0) begin
                     mem_read_strobe_n <= 1'b1;
                     ram_write_strobe_n <= 1'b1;
                     // Synchronised data has been stable for the pulse
                     if (!acc_we) begin
                        if (!acc8)
                           rd_data <= din_s;
                        else if (!half)
                           rd_data[7:0] <= din_s[7:0];
                        else
                           rd_data[15:8] <= din_s[7:0];
                     end
                     if (acc8 && !half) begin
                        half <= 1'b1;
                        byte_half_select <= 1'b1;
                        cnt <= AS_C;
                        st <= SRM_SETUP;
                     end else begin
                        rom_select_n <= 1'b1;
                        ram_select_n <= 1'b1;
                        mem_data_oe <= 1'b0;
                        dsp_done <= (owner == SRM_OWN_DSP);
                        cpu_done <= (owner == SRM_OWN_CPU);
                        if (owner == SRM_OWN_BOOT)
                           run <= 1'b1;
                        cnt <= DF_C;
                        st <= SRM_GAP;
                     end
                  end else begin
                     cnt <= cnt - 4'h1;
                  end
               end
               SRM_GAP: begin
                  // Lets the memory release the bus before the next cycle
                  if (cnt == 4'h0)
                     st <= SRM_IDLE;
                  else
                     cnt <= cnt - 4'h1;
               end
               SRM_SLEEP: begin
                  st <= SRM_SLEEP;
               end
               default: begin
                  st <= SRM_IDLE;
               end
            endcase
         end
      end
   end

   property p_sel_excl;
      @(posedge mclk) disable iff (!rst_n)
         !(!rom_select_n && !ram_select_n);
   endproperty
   a_sel_excl: assert property (p_sel_excl)
      else $error("both selects low");

   property p_strobe_excl;
      @(posedge mclk) disable iff (!rst_n)
         !(!mem_read_strobe_n && !ram_write_strobe_n);
   endproperty
   a_strobe_excl: assert property (p_strobe_excl)
      else $error("both strobes low");

   property p_rom_nowrite;
      @(posedge mclk) disable iff (!rst_n)
         !ram_write_strobe_n |-> rom_select_n && !ram_select_n;
   endproperty
   a_rom_nowrite: assert property (p_rom_nowrite)
      else $error("write outside RAM");

   property p_data_float;
      @(posedge mclk) disable iff (!rst_n)
         mem_data_oe |-> !ram_select_n && acc_we && mem_read_strobe_n;
   endproperty
   a_data_float: assert property (p_data_float)
      else $error("data bus driven without RAM write");

   property p_wr_drive;
      @(posedge mclk) disable iff (!rst_n)
         $fell(ram_write_strobe_n) |-> mem_data_oe && $past(mem_data_oe);
   endproperty
   a_wr_drive: assert property (p_wr_drive)
      else $error("write strobe without data");

   property p_sleep_float;
      @(posedge mclk) disable iff (!rst_n)
         (ce && !sleep_s) |=> !pins_oe && !mem_data_oe && !run;
   endproperty
   a_sleep_float: assert property (p_sleep_float)
      else $error("pins not floated in sleep");

   property p_boot_addr;
      @(posedge mclk) disable iff (!rst_n)
         (!run && !rom_select_n) |-> mem_word_addr == `SRM_BOOT_ADDR;
   endproperty
   a_boot_addr: assert property (p_boot_addr)
      else $error("first fetch not at boot word");

   property p_idle_hold;
      @(posedge mclk) disable iff (!rst_n)
         (st == SRM_IDLE && $past(st) == SRM_IDLE) |->
            $stable(mem_word_addr) && $stable(byte_half_select);
   endproperty
   a_idle_hold: assert property (p_idle_hold)
      else $error("bus pins toggled while idle");

   property p_pulse;
      @(posedge mclk) disable iff (!rst_n)
         ($fell(mem_read_strobe_n) && ce) |-> !mem_read_strobe_n[*2];
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("read strobe too short");

   property p_half16;
      @(posedge mclk) disable iff (!rst_n)
         (!acc8 && st == SRM_STROBE) |-> !byte_half_select;
   endproperty
   a_half16: assert property (p_half16)
      else $error("byte select used in word mode");
endmodule
`default_nettype wire

// ---- test/srm_mem_model.sv ----
`default_nettype none
module srm_mem_model
   import srm_pkg::*;
(
   input wire logic mclk,
   input wire logic ram_is_8bit,
   input wire srm_addr_t mem_word_addr,
   input wire srm_data_t mem_data_out,
   input wire logic mem_data_oe,
   input wire logic rom_select_n,
   input wire logic ram_select_n,
   input wire logic mem_read_strobe_n,
   input wire logic ram_write_strobe_n,
   input wire logic byte_half_select,
   output srm_data_t mem_data_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] ram8 [0:1023];
   srm_data_t ram16 [0:511];
   srm_data_t last = 16'h0000;
   // Released bus shows a toggling pattern, never a stale value
   always_comb begin
      mem_data_in = ~last;
      if (!mem_read_strobe_n && !rom_select_n)
         mem_data_in = {mem_word_addr[18:16], mem_word_addr[12:0]} ^ 16'hA5C3;
      else if (!mem_read_strobe_n && !ram_select_n && ram_is_8bit)
         mem_data_in[7:0] = ram8[{mem_word_addr[8:0], byte_half_select}];
      else if (!mem_read_strobe_n && !ram_select_n)
         mem_data_in = ram16[mem_word_addr[8:0]];
   end
   always @(posedge mclk) begin
      last <= mem_data_in;
      if (!ram_write_strobe_n && !ram_select_n && mem_data_oe && ram_is_8bit)
         ram8[{mem_word_addr[8:0], byte_half_select}] <= mem_data_out[7:0];
      else if (!ram_write_strobe_n && !ram_select_n && mem_data_oe)
         ram16[mem_word_addr[8:0]] <= mem_data_out;
   end
endmodule
`default_nettype wire

// ---- test/tb.sv ----
`default_nettype none
module tb import srm_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, arst_n, sleep_request_n, ram_is_8bit, ce;
   logic dsp_req, dsp_we, dsp_ram, cpu_req, cpu_we, cpu_ram;
   srm_addr_t dsp_addr, cpu_addr, mem_word_addr, seen_addr, prev_addr, a;
   srm_data_t dsp_wdata, cpu_wdata, mem_data_in, mem_data_out, rd_data, d;
   logic mem_data_oe, pins_oe, rom_select_n, ram_select_n, idle_prev;
   logic mem_read_strobe_n, ram_write_strobe_n, byte_half_select, run;
   logic dsp_done, cpu_done;
   logic [15:0] ref16 [int];
   logic [7:0] ref8 [int];
   int fails = 0;
   int num_checks = 0;
   always #4 mclk = ~mclk;
   srm_mem_port DUT (.mclk(mclk), .arst_n(arst_n), .ce(ce),
      .sleep_request_n(sleep_request_n), .ram_is_8bit(ram_is_8bit),
      .dsp_req(dsp_req), .dsp_we(dsp_we), .dsp_ram(dsp_ram),
      .dsp_addr(dsp_addr), .dsp_wdata(dsp_wdata), .cpu_req(cpu_req),
      .cpu_we(cpu_we), .cpu_ram(cpu_ram), .cpu_addr(cpu_addr),
      .cpu_wdata(cpu_wdata), .mem_data_in(mem_data_in),
      .mem_word_addr(mem_word_addr), .mem_data_out(mem_data_out),
      .mem_data_oe(mem_data_oe), .pins_oe(pins_oe),
      .rom_select_n(rom_select_n), .ram_select_n(ram_select_n),
      .mem_read_strobe_n(mem_read_strobe_n),
      .ram_write_strobe_n(ram_write_strobe_n),
      .byte_half_select(byte_half_select), .run(run), .rd_data(rd_data),
      .dsp_done(dsp_done), .cpu_done(cpu_done));
   srm_mem_model MEM (.mclk(mclk), .ram_is_8bit(ram_is_8bit),
      .mem_word_addr(mem_word_addr), .mem_data_out(mem_data_out),
      .mem_data_oe(mem_data_oe), .rom_select_n(rom_select_n),
      .ram_select_n(ram_select_n), .mem_read_strobe_n(mem_read_strobe_n),
      .ram_write_strobe_n(ram_write_strobe_n),
      .byte_half_select(byte_half_select), .mem_data_in(mem_data_in));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks=%0d mismatches=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   always @(negedge mclk) begin
      if (arst_n && pins_oe) begin
         chk(!rom_select_n && !ram_select_n, 0);
         chk(!mem_read_strobe_n && !ram_write_strobe_n, 0);
         if (mem_data_oe)
            chk(rom_select_n && mem_read_strobe_n, 1);
         if (!ram_write_strobe_n)
            chk(rom_select_n, 1);
         if (!mem_read_strobe_n || !ram_write_strobe_n)
            seen_addr <= mem_word_addr;
         if (idle_prev && rom_select_n && ram_select_n)
            chk(mem_word_addr, prev_addr);
      end
      idle_prev <= arst_n && pins_oe && rom_select_n && ram_select_n;
      prev_addr <= mem_word_addr;
   end
   // Extra counts the cycles spent waiting behind the other requester
   task automatic access(input logic who, we, ram, input int extra,
                         input srm_addr_t a, input srm_data_t d);
      int n;
      logic m8;
      n = 0;
      m8 = ram_is_8bit && ram;
      if (who)
         {cpu_req, cpu_we, cpu_ram, cpu_addr, cpu_wdata} <= {1'b1, we, ram, a, d};
      else
         {dsp_req, dsp_we, dsp_ram, dsp_addr, dsp_wdata} <= {1'b1, we, ram, a, d};
      do begin
         @(posedge mclk);
         #1;
         n++;
      end while ((who ? cpu_done : dsp_done) !== 1'b1 && n < 200);
      chk(n, (m8 ? 20 : 17) + extra);
      chk(seen_addr, a);
      if (!ram)
         chk(rd_data, {a[18:16], a[12:0]} ^ 16'hA5C3);
      else if (!we && m8)
         chk(rd_data, {ref8[{a, 1'b1}], ref8[{a, 1'b0}]});
      else if (!we)
         chk(rd_data, ref16[a]);
      else if (m8) begin
         ref8[{a, 1'b1}] = d[15:8];
         ref8[{a, 1'b0}] = d[7:0];
         chk(MEM.ram8[{a[8:0], 1'b0}], d[7:0]);
         chk(MEM.ram8[{a[8:0], 1'b1}], d[15:8]);
      end else begin
         ref16[a] = d;
         chk(MEM.ram16[a[8:0]], d);
      end
      @(posedge mclk);
      if (who)
         cpu_req <= 1'b0;
      else
         dsp_req <= 1'b0;
      repeat (8) @(posedge mclk);
   endtask
   task automatic do_reset();
      int n;
      arst_n <= 1'b0;
      repeat (4) @(posedge mclk);
      arst_n <= 1'b1;
      n = 0;
      while (rom_select_n !== 1'b0 && n < 50) begin
         @(posedge mclk);
         n++;
      end
      #1;
      chk(mem_word_addr, 19'h00100);
      chk(run, 0);
      repeat (40) @(posedge mclk);
      chk(run, 1);
   endtask
   initial begin
      {mclk, arst_n, ram_is_8bit, dsp_req, dsp_we, dsp_ram, cpu_req} = 0;
      {cpu_we, cpu_ram, dsp_addr, cpu_addr, dsp_wdata, cpu_wdata} = 0;
      sleep_request_n = 1'b1;
      ce = 1'b1;
      void'($urandom(32'hd7955464));
      do_reset();
      for (int m = 0; m < 2; m++) begin
         ram_is_8bit <= m[0];
         repeat (8) @(posedge mclk);
         for (int i = 0; i < 10; i++) begin
            a = srm_addr_t'($urandom_range(511, 0));
            d = srm_data_t'($urandom);
            access(i[0], 1, 1, 0, a, d);
            access(!i[0], 0, 1, 0, a, 0);
            access(i[0], 1, 0, 0, srm_addr_t'($urandom), d);
         end
         // Control processor went last, so the signal processor wins
         fork
            access(0, 0, 0, 0, srm_addr_t'($urandom), 0);
            access(1, 0, 1, 24, a, 0);
         join
      end
      // Frozen clock enable must hold off the sleep request
      ce <= 1'b0;
      sleep_request_n <= 1'b0;
      repeat (6) @(posedge mclk);
      chk(pins_oe, 1);
      ce <= 1'b1;
      repeat (10) @(posedge mclk);
      chk({pins_oe, run, mem_data_oe}, 0);
      sleep_request_n <= 1'b1;
      repeat (10) @(posedge mclk);
      chk(pins_oe, 0);
      do_reset();
      chk(pins_oe, 1);
      give_verdict();
   end
   initial begin
      #200000;
      fails++;
      give_verdict();
   end
endmodule
`default_nettype wire
